// ==== bench/core_pipeline_bank_memory_tb.sv ====
`timescale 1ns/1ps
module core_pipeline_bank_memory_tb
    import cpb_pkg::*;
();
    logic               mclk;
    logic               reset;
    logic [PROG_AW-1:0] prog_addr;
    logic [INSN_W-1:0]  prog_data;
    logic               phase_one;
    logic               phase_two;
    logic               phase_three;
    logic               phase_four;
    logic [7:0]         working_value;
    logic [7:0]         status_value;
    int                 fails = 0;
    int                 check_count = 0;

    cpb_core DUT (.mclk(mclk), .reset(reset), .prog_addr(prog_addr), .prog_data(prog_data),
        .phase_one(phase_one), .phase_two(phase_two), .phase_three(phase_three),
        .phase_four(phase_four), .working_value(working_value), .status_value(status_value));
    cpb_prog_mem PM (.prog_addr(prog_addr), .prog_data(prog_data));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    // Loads the program, then resets; returns just after the last reset edge
    task automatic start(input logic [INSN_W-1:0] p [$]);
        foreach (PM.mem[i]) PM.mem[i] = (i < p.size()) ? p[i] : NOP_WORD;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        #1;
        chk8("reset accumulator", 8'h00, working_value);
        chk8("reset status", 8'h18, status_value);
        chk16("reset address", 16'h0000, {5'h00, prog_addr});
    endtask : start

    task automatic run_prog(input logic [INSN_W-1:0] p [$]);
        start(p);
        repeat (160) @(posedge mclk);
        #1;
    endtask : run_prog

    ////////////////////////////////////////////////////////////////////////////////
    // Phase rotation, fetch stepping and one result per instruction cycle
    task automatic test_phases();
        logic [INSN_W-1:0] p [$] = '{14'h3011, 14'h3022, 14'h3033};
        start(p);
        for (int k = 1; k <= 12; k++)
        begin
            @(posedge mclk);
            #1;
            chk16("phase", 16'h1 << (k % 4),
                {12'h000, phase_four, phase_three, phase_two, phase_one});
            chk16("fetch address", 16'((k - 1) / 4), {5'h00, prog_addr});
            chk8("step result", (k < 8) ? 8'h00 : 8'(17 * (k / 4 - 1)), working_value);
        end
    endtask : test_phases

    task automatic test_add();
        logic [INSN_W-1:0] p [$] = '{14'h300F, 14'h3E01, 14'h2802};
        run_prog(p);
        chk8("add result", 8'h10, working_value);
        chk8("add flags", 8'h1A, status_value);
    endtask : test_add

    task automatic test_sub();
        logic [INSN_W-1:0] p [$] = '{14'h3010, 14'h3C10, 14'h2802};
        run_prog(p);
        chk8("sub result", 8'h00, working_value);
        chk8("sub flags", 8'h1F, status_value);
    endtask : test_sub

    // Write 70h in bank zero, read it back as F0h in bank one
    task automatic test_bank();
        logic [INSN_W-1:0] p [$] = '{14'h305A, 14'h00F0, 14'h1683, 14'h3000, 14'h0870, 14'h2805};
        run_prog(p);
        chk8("common ram", 8'h5A, working_value);
        chk8("bank status", 8'h38, status_value);
    endtask : test_bank

    // Pointer to A0h, store via the port, read back, add an unimplemented cell
    task automatic test_indirect();
        logic [INSN_W-1:0] p [$] = '{14'h30A0, 14'h0084, 14'h3033, 14'h0080,
            14'h3000, 14'h0800, 14'h0707, 14'h2807};
        run_prog(p);
        chk8("indirect read", 8'h33, working_value);
        chk8("indirect flags", 8'h18, status_value);
    endtask : test_indirect

    // Jump over a word, then write the low counter to skip another
    task automatic test_jump();
        logic [INSN_W-1:0] p [$] = '{14'h3001, 14'h2803, 14'h30EE, 14'h3E02,
            14'h3E04, 14'h0082, 14'h3E40, 14'h2807};
        run_prog(p);
        chk8("flushed words", 8'h07, working_value);
        chk8("jump flags", 8'h18, status_value);
    endtask : test_jump

    // Counted loop with a zero skip, a call, a literal return and a bit skip
    task automatic test_call();
        logic [INSN_W-1:0] p [$] = '{14'h3003, 14'h00A0, 14'h0BA0, 14'h2802, 14'h2009,
            14'h3E10, 14'h1903, 14'h3EF0, 14'h2808, 14'h3405};
        run_prog(p);
        chk8("call result", 8'h15, working_value);
        chk8("call flags", 8'h18, status_value);
    endtask : test_call

    // Rotate right through carry, complement and swap a file register
    task automatic test_shift();
        logic [INSN_W-1:0] p [$] = '{14'h3081, 14'h00A1, 14'h0CA1, 14'h09A1, 14'h0E21,
            14'h2805};
        run_prog(p);
        chk8("shift result", 8'hFB, working_value);
        chk8("shift flags", 8'h19, status_value);
    endtask : test_shift

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    initial
    begin
        #50000;
        fails++;
        results();
    end

    initial
    begin
        reset = 1'b1;
        test_phases();
        test_add();
        test_sub();
        test_bank();
        test_indirect();
        test_jump();
        test_call();
        test_shift();
        results();
    end
endmodule : core_pipeline_bank_memory_tb

// ==== bench/cpb_prog_mem.sv ====
`timescale 1ns/1ps
module cpb_prog_mem
    import cpb_pkg::*;
(
    input  wire logic [PROG_AW-1:0] prog_addr,
    output logic      [INSN_W-1:0]  prog_data
);
    ////////////////////////////////////////////////////////////////////////////////
    // Full 2K word store, loaded by the bench before each reset
    logic [INSN_W-1:0] mem [0:(1<<PROG_AW)-1];

    // Whole word every cycle, no wait state
    assign prog_data = mem[prog_addr];
endmodule : cpb_prog_mem

// ==== design/cpb_alu.sv ====
`timescale 1ns/1ps
module cpb_alu
    import cpb_pkg::*;
(
    input  cpb_alu_op_type op,
    input  logic [7:0]     acc,
    input  logic [7:0]     opnd,
    input  logic           carry_in,
    input  logic [2:0]     bit_sel,
    output logic [7:0]     result,
    output logic           carry_out,
    output logic           nibble_carry_out,
    output logic           zero_out
);

    logic [8:0] sum;
    logic [4:0] low;

    // Subtraction adds the inverted accumulator plus one, so carries mean no borrow
    always_comb
    begin
        sum       = 9'h000;
        low       = 5'h00;
        result    = opnd;
        carry_out = carry_in;
        case (op)
            ALU_MOVB: result = opnd;
            ALU_MOVA: result = acc;
            ALU_ADD:
            begin
                sum       = {1'b0, opnd} + {1'b0, acc};
                low       = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
                result    = sum[7:0];
                carry_out = sum[8];
            end
            ALU_SUB:
            begin
                sum       = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
                low       = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                result    = sum[7:0];
                carry_out = sum[8];
            end
            ALU_AND:  result = opnd & acc;
            ALU_IOR:  result = opnd | acc;
            ALU_XOR:  result = opnd ^ acc;
            ALU_COM:  result = ~opnd;
            ALU_INC:  result = opnd + 8'h01;
            ALU_DEC:  result = opnd - 8'h01;
            ALU_RLF:
            begin
                result    = {opnd[6:0], carry_in};
                carry_out = opnd[7];
            end
            ALU_RRF:
            begin
                result    = {carry_in, opnd[7:1]};
                carry_out = opnd[0];
            end
            ALU_SWAP: result = {opnd[3:0], opnd[7:4]};
            ALU_CLR:  result = 8'h00;
            ALU_BCLR: result = opnd & ~(8'h01 << bit_sel);
            ALU_BSET: result = opnd | (8'h01 << bit_sel);
            default:  result = opnd;
        endcase
        nibble_carry_out = low[4];
        zero_out         = (result == 8'h00);
    end

endmodule : cpb_alu

// ==== design/cpb_core.sv ====
// Function
// - Each instruction is one 14-bit word from a separate program bus.
// - Fetch overlaps execution; every instruction takes one cycle except flow changes.
// - Program counter addresses up to 2K internal 14-bit words.
// - ALU is 8 bits: add, subtract, shift, logic, one's complement.
// - Working accumulator is 8 bits and has no data memory address.
// - Two-operand ops use accumulator plus file register or literal.
// - ALU sets carry, nibble carry, zero; subtraction carries mean no borrow.
// - Clock is divided into four phases forming one instruction cycle.
// - Program counter steps in phase one; fetch latched in phase four.
// - Fetch in one cycle, execute in the next, one per cycle.
// - Flow changes take two cycles; the prefetched word is discarded.
// - Instruction latch loads phase one; read phase two; write phase four.
// - Status bit 5 selects bank zero or bank one.
// - Low 32 addresses per bank are special registers, including program counter.
// - General RAM at 20h-7Fh bank zero and A0h-BFh bank one.
// - Bank-one F0h-FFh reach the same cells as 70h-7Fh.
// - General registers reachable directly and through the file select pointer.
// - Indirect port, pc low, status, pointer, pc latch mirrored in both banks.
`timescale 1ns/1ps
module cpb_core
    import cpb_pkg::*;
(
    input  logic               mclk,
    input  logic               reset,
    output logic [PROG_AW-1:0] prog_addr,
    input  logic [INSN_W-1:0]  prog_data,
    output logic               phase_one,
    output logic               phase_two,
    output logic               phase_three,
    output logic               phase_four,
    output logic [7:0]         working_value,
    output logic [7:0]         status_value
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    cpb_phase_type     phase_reg, phase_next;
    logic [PC_W-1:0]   pc_reg, pc_next;
    logic [PC_W-1:0]   fetch_pc_reg, fetch_pc_next;
    logic [INSN_W-1:0] fetch_reg, fetch_next;
    logic [INSN_W-1:0] instr_latch, instr_next;
    logic              flush_reg, flush_next;
    logic [7:0]        operand_reg, operand_next;
    logic [7:0]        w_reg, w_next;
    logic [7:0]        status_reg, status_next;
    logic [7:0]        fsp_reg, fsp_next;
    logic [7:0]        pc_upper_reg, pc_upper_next;
    logic [7:0]        gpr_reg [GPR_DEPTH];
    logic [7:0]        gpr_next [GPR_DEPTH];
    logic [PC_W-1:0]   stack_reg [STACK_DEPTH];
    logic [PC_W-1:0]   stack_next [STACK_DEPTH];
    logic [2:0]        sp_reg, sp_next;

    // Hit flag in bit 7, cell index below
    function automatic logic [7:0] gpr_index(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (!a[7] && a[6:0] >= GPR_BASE)
            r = {1'b1, 7'(a[6:0] - GPR_BASE)};
        else if (a >= GPR1_LO && a <= GPR1_HI)
            r = {1'b1, 7'(a[6:0] + GPR_BANK1_OFS)};
        else if (a >= COMMON_LO)
            r = {1'b1, 7'(a[6:0] - GPR_BASE)};
        return r;
    endfunction : gpr_index

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of the executing word

    cpb_alu_op_type dec_op;
    logic           dec_lit, dec_wr_w, dec_wr_f, dec_z, dec_cdc, dec_c;
    logic           dec_skipz, dec_btest, dec_bset, dec_call, dec_jump_op, dec_ret;

    always_comb
    begin
        dec_op    = ALU_MOVB;
        dec_lit   = 1'b0;
        dec_wr_w  = 1'b0;
        dec_wr_f  = 1'b0;
        dec_z     = 1'b0;
        dec_cdc   = 1'b0;
        dec_c     = 1'b0;
        dec_skipz = 1'b0;
        dec_btest = 1'b0;
        dec_bset  = 1'b0;
        dec_call  = 1'b0;
        dec_jump_op  = 1'b0;
        dec_ret   = 1'b0;
        casez (instr_latch)
            14'b00_0000_1???_????:
            begin
                dec_op   = ALU_MOVA;
                dec_wr_f = 1'b1;
            end
            14'b00_0000_0000_100?: dec_ret = 1'b1;
            14'b00_0001_????_????:
            begin
                dec_op   = ALU_CLR;
                dec_wr_f = instr_latch[7];
                dec_wr_w = ~instr_latch[7];
                dec_z    = 1'b1;
            end
            14'b00_????_????_????:
            begin
                dec_wr_f = instr_latch[7];
                dec_wr_w = ~instr_latch[7];
                dec_z    = 1'b1;
                case (instr_latch[11:8])
                    4'h2:
                    begin
                        dec_op  = ALU_SUB;
                        dec_cdc = 1'b1;
                    end
                    4'h3: dec_op = ALU_DEC;
                    4'h4: dec_op = ALU_IOR;
                    4'h5: dec_op = ALU_AND;
                    4'h6: dec_op = ALU_XOR;
                    4'h7:
                    begin
                        dec_op  = ALU_ADD;
                        dec_cdc = 1'b1;
                    end
                    4'h8: dec_op = ALU_MOVB;
                    4'h9: dec_op = ALU_COM;
                    4'hA: dec_op = ALU_INC;
                    4'hB,
                    4'hF:
                    begin
                        dec_op    = instr_latch[10] ? ALU_INC : ALU_DEC;
                        dec_z     = 1'b0;
                        dec_skipz = 1'b1;
                    end
                    4'hC,
                    4'hD:
                    begin
                        dec_op = instr_latch[8] ? ALU_RLF : ALU_RRF;
                        dec_z  = 1'b0;
                        dec_c  = 1'b1;
                    end
                    4'hE:
                    begin
                        dec_op = ALU_SWAP;
                        dec_z  = 1'b0;
                    end
                    default:
                    begin
                        dec_wr_f = 1'b0;
                        dec_wr_w = 1'b0;
                        dec_z    = 1'b0;
                    end
                endcase
            end
            14'b01_0???_????_????:
            begin
                dec_op   = instr_latch[10] ? ALU_BSET : ALU_BCLR;
                dec_wr_f = 1'b1;
            end
            14'b01_1???_????_????:
            begin
                dec_btest = 1'b1;
                dec_bset  = instr_latch[10];
            end
            14'b10_0???_????_????: dec_call = 1'b1;
            14'b10_1???_????_????: dec_jump_op = 1'b1;
            default:
            begin
                dec_lit  = 1'b1;
                dec_wr_w = 1'b1;
                dec_z    = 1'b1;
                casez (instr_latch[11:8])
                    4'b00??: dec_z = 1'b0;
                    4'b01??:
                    begin
                        dec_z   = 1'b0;
                        dec_ret = 1'b1;
                    end
                    4'b1000: dec_op = ALU_IOR;
                    4'b1001: dec_op = ALU_AND;
                    4'b1010: dec_op = ALU_XOR;
                    4'b110?:
                    begin
                        dec_op  = ALU_SUB;
                        dec_cdc = 1'b1;
                    end
                    4'b111?:
                    begin
                        dec_op  = ALU_ADD;
                        dec_cdc = 1'b1;
                    end
                    default:
                    begin
                        dec_wr_w = 1'b0;
                        dec_z    = 1'b0;
                    end
                endcase
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory addressing and read

    logic [7:0] eff_addr, map, read_data, opnd, alu_res, common_mirror;
    logic       alu_c, alu_nc, alu_z, is_indirect;

    // The indirect port has no cell: its address is swapped for the pointer
    assign is_indirect = (instr_latch[6:0] == ADDR_INDIRECT);
    assign eff_addr    = is_indirect ? fsp_reg
                                     : {status_reg[BIT_BANK], instr_latch[6:0]};
    assign map         = gpr_index(eff_addr);
    assign opnd        = dec_lit ? instr_latch[7:0] : operand_reg;
    assign common_mirror = gpr_reg[{COMMON_IDX_HI, eff_addr[3:0]}];

    // Special registers decode on the low seven bits, so both banks see them
    always_comb
    begin
        read_data = 8'h00;
        if (map[7])
            read_data = gpr_reg[map[6:0]];
        else
            case (eff_addr[6:0])
                ADDR_PC_LOW:   read_data = fetch_pc_reg[7:0];
                ADDR_STATUS:   read_data = status_reg;
                ADDR_FSP:      read_data = fsp_reg;
                ADDR_PC_UPPER: read_data = pc_upper_reg;
                default:       read_data = 8'h00;
            endcase
    end

    cpb_alu u_alu
    (
        .op               (dec_op),
        .acc              (w_reg),
        .opnd             (opnd),
        .carry_in         (status_reg[BIT_C]),
        .bit_sel          (instr_latch[9:7]),
        .result           (alu_res),
        .carry_out        (alu_c),
        .nibble_carry_out (alu_nc),
        .zero_out         (alu_z)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Phase sequencer and pipeline

    logic redirect;

    always_comb
    begin
        phase_next    = phase_reg;
        pc_next       = pc_reg;
        fetch_pc_next = fetch_pc_reg;
        fetch_next    = fetch_reg;
        instr_next    = instr_latch;
        flush_next    = flush_reg;
        operand_next  = operand_reg;
        w_next        = w_reg;
        status_next   = status_reg;
        fsp_next      = fsp_reg;
        pc_upper_next = pc_upper_reg;
        gpr_next      = gpr_reg;
        stack_next    = stack_reg;
        sp_next       = sp_reg;
        redirect      = 1'b0;
        case (phase_reg)
            PH_ONE:
            begin
                phase_next    = PH_TWO;
                fetch_pc_next = pc_reg;
                pc_next       = pc_reg + 13'h0001;
                instr_next    = flush_reg ? NOP_WORD : fetch_reg;
                flush_next    = 1'b0;
            end
            PH_TWO:
            begin
                phase_next   = PH_THREE;
                operand_next = read_data;
            end
            PH_THREE: phase_next = PH_FOUR;
            PH_FOUR:
            begin
                phase_next = PH_ONE;
                fetch_next = prog_data;
                if (dec_wr_w)
                    w_next = alu_res;
                if (dec_wr_f && map[7])
                    gpr_next[map[6:0]] = alu_res;
                if (dec_wr_f && !map[7])
                    case (eff_addr[6:0])
                        ADDR_PC_LOW:
                        begin
                            pc_next  = {pc_upper_reg[4:0], alu_res};
                            redirect = 1'b1;
                        end
                        ADDR_STATUS: status_next = (alu_res & ~STATUS_RO_MASK)
                                                 | (status_reg & STATUS_RO_MASK);
                        ADDR_FSP:    fsp_next = alu_res;
                        ADDR_PC_UPPER: pc_upper_next = alu_res;
                        default:     fsp_next = fsp_reg;
                    endcase
                if (dec_z)
                    status_next[BIT_Z] = alu_z;
                if (dec_cdc)
                begin
                    status_next[BIT_C]  = alu_c;
                    status_next[BIT_NIB] = alu_nc;
                end
                if (dec_c)
                    status_next[BIT_C] = alu_c;
                if (dec_call)
                begin
                    stack_next[sp_reg] = fetch_pc_reg;
                    sp_next            = sp_reg + 3'h1;
                end
                if (dec_call || dec_jump_op)
                begin
                    pc_next  = {pc_upper_reg[4:3], instr_latch[10:0]};
                    redirect = 1'b1;
                end
                if (dec_ret)
                begin
                    pc_next  = stack_reg[sp_reg - 3'h1];
                    sp_next  = sp_reg - 3'h1;
                    redirect = 1'b1;
                end
                if ((dec_skipz && alu_z) || (dec_btest && (opnd[instr_latch[9:7]] == dec_bset)))
                    redirect = 1'b1;
                flush_next = redirect;
            end
            default: phase_next = PH_ONE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            phase_reg    <= PH_ONE;
            pc_reg       <= PC_RST;
            fetch_pc_reg <= PC_RST;
            fetch_reg    <= NOP_WORD;
            instr_latch  <= NOP_WORD;
            flush_reg    <= 1'b1;
            operand_reg  <= 8'h00;
            w_reg        <= W_RST;
            status_reg   <= STATUS_RST;
            fsp_reg      <= FSP_RST;
            pc_upper_reg <= PC_UPPER_RST;
            gpr_reg      <= '{default: 8'h00};
            stack_reg    <= '{default: PC_RST};
            sp_reg       <= 3'h0;
        end
        else
        begin
            phase_reg    <= phase_next;
            pc_reg       <= pc_next;
            fetch_pc_reg <= fetch_pc_next;
            fetch_reg    <= fetch_next;
            instr_latch  <= instr_next;
            flush_reg    <= flush_next;
            operand_reg  <= operand_next;
            w_reg        <= w_next;
            status_reg   <= status_next;
            fsp_reg      <= fsp_next;
            pc_upper_reg <= pc_upper_next;
            gpr_reg      <= gpr_next;
            stack_reg    <= stack_next;
            sp_reg       <= sp_next;
        end
    end

    assign prog_addr     = fetch_pc_reg[PROG_AW-1:0];
    assign phase_one     = (phase_reg == PH_ONE);
    assign phase_two     = (phase_reg == PH_TWO);
    assign phase_three   = (phase_reg == PH_THREE);
    assign phase_four    = (phase_reg == PH_FOUR);
    assign working_value = w_reg;
    assign status_value  = status_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence phase_walk_s;
        phase_reg == PH_TWO ##1 phase_reg == PH_THREE ##1 phase_reg == PH_FOUR
            ##1 phase_reg == PH_ONE;
    endsequence

    sequence flush_walk_s;
        flush_reg && phase_reg == PH_ONE ##1 instr_latch == NOP_WORD && !flush_reg;
    endsequence

    phase_order_a: assert property (phase_reg == PH_ONE |=> phase_walk_s)
        else $error("phase order broken");
    pc_step_a: assert property (phase_reg == PH_ONE |=>
        pc_reg == $past(pc_reg) + 13'h0001 && fetch_pc_reg == $past(pc_reg))
        else $error("program counter did not step in phase one");
    fetch_latch_a: assert property (phase_reg == PH_FOUR |=>
        fetch_reg == $past(prog_data))
        else $error("fetch not latched in phase four");
    insn_load_a: assert property (phase_reg == PH_ONE && !flush_reg |=>
        instr_latch == $past(fetch_reg))
        else $error("prefetched word not executed next cycle");
    branch_flush_a: assert property (phase_reg == PH_FOUR && redirect |=>
        flush_walk_s)
        else $error("prefetched word not discarded");
    w_write_a: assert property (phase_reg != PH_FOUR |=> $stable(w_reg))
        else $error("accumulator written outside phase four");
    file_write_a: assert property (phase_reg == PH_FOUR && dec_wr_f |=>
        $stable(w_reg))
        else $error("file write disturbed accumulator");
    zero_flag_a: assert property (phase_reg == PH_FOUR && dec_z |=>
        status_reg[BIT_Z] == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");
    common_ram_a: assert property (phase_reg == PH_TWO && eff_addr >= COMMON_LO |=>
        operand_reg == $past(common_mirror))
        else $error("common ram not mirrored");
    unmapped_zero_a: assert property (phase_reg == PH_TWO && !map[7] &&
        eff_addr[6:0] > ADDR_PC_UPPER |=> operand_reg == 8'h00)
        else $error("unimplemented address did not read zero");

endmodule : cpb_core

// ==== design/cpb_pkg.sv ====
package cpb_pkg;

    localparam int          PROG_AW        = 11;
    localparam int          PC_W           = 13;
    localparam int          INSN_W         = 14;
    localparam int          GPR_DEPTH      = 128;
    localparam int          STACK_DEPTH    = 8;

    localparam logic [6:0]  ADDR_INDIRECT  = 7'h00;
    localparam logic [6:0]  ADDR_PC_LOW    = 7'h02;
    localparam logic [6:0]  ADDR_STATUS    = 7'h03;
    localparam logic [6:0]  ADDR_FSP       = 7'h04;
    localparam logic [6:0]  ADDR_PC_UPPER  = 7'h0A;

    localparam logic [6:0]  GPR_BASE       = 7'h20;
    localparam logic [6:0]  GPR_BANK1_OFS  = 7'h40;
    localparam logic [7:0]  GPR1_LO        = 8'hA0;
    localparam logic [7:0]  GPR1_HI        = 8'hBF;
    localparam logic [7:0]  COMMON_LO      = 8'hF0;
    localparam logic [2:0]  COMMON_IDX_HI  = 3'h5;

    localparam int          BIT_C          = 0;
    localparam int          BIT_NIB        = 1;
    localparam int          BIT_Z          = 2;
    localparam int          BIT_BANK       = 5;

    localparam logic [7:0]  STATUS_RST     = 8'h18;
    localparam logic [7:0]  STATUS_RO_MASK = 8'h18;
    localparam logic [7:0]  FSP_RST        = 8'h00;
    localparam logic [7:0]  PC_UPPER_RST   = 8'h00;
    localparam logic [7:0]  W_RST          = 8'h00;
    localparam logic [12:0] PC_RST         = 13'h0000;
    localparam logic [13:0] NOP_WORD       = 14'h0000;

    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} cpb_phase_type;

    typedef enum logic [3:0]
    {
        ALU_MOVB, ALU_MOVA, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM,
        ALU_INC, ALU_DEC, ALU_RLF, ALU_RRF, ALU_SWAP, ALU_CLR, ALU_BCLR, ALU_BSET
    } cpb_alu_op_type;

endpackage : cpb_pkg
